// *** inc/fasp_pkg.sv ***
package fasp_pkg;
    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] REG_OPA = 8'h00;
    localparam logic [7:0] REG_OPB = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0C;
    localparam logic [7:0] REG_FLAGS = 8'h10;
    localparam logic [7:0] REG_COUNT = 8'h14;
    // single precision field layout
    localparam int unsigned SIGN_BIT = 31;
    localparam int unsigned EXP_LSB = 23;
    localparam int unsigned EXP_W = 8;
    localparam int unsigned FRAC_W = 23;
    localparam logic [7:0] EXP_ALL_ONES = 8'hFF;
    localparam logic [7:0] EXP_ZERO = 8'h00;
    localparam logic [9:0] EXP_BIAS = 10'h07F;
    // reciprocal seed: biased result = 253 - biased input
    localparam logic [7:0] RECIP_EXP_BASE = 8'hFD;
    // unbiased exponent above +125 means biased above 252
    localparam logic [7:0] RECIP_ZERO_LIMIT = 8'hFC;
    // square-root seed: biased result = 126 - floor(e/2)
    localparam logic [9:0] RSQ_EXP_BASE = 10'h07E;
    // seed table geometry
    localparam int unsigned RECIP_IDX_W = 7;
    localparam int unsigned RECIP_SEED_W = 8;
    localparam int unsigned RSQ_FRAC_IDX_W = 6;
    localparam int unsigned RSQ_SEED_W = 4;
    localparam int unsigned TABLE_DEPTH = 128;
    // special results
    localparam logic [31:0] NAN_RESULT = 32'hFFFF_FFFF;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // flag bit positions in the flags word
    localparam int unsigned FLG_ZERO = 0;
    localparam int unsigned FLG_UNDERFLOW = 1;
    localparam int unsigned FLG_NEGATIVE = 2;
    localparam int unsigned FLG_OVERFLOW = 3;
    localparam int unsigned FLG_CARRY = 4;
    localparam int unsigned FLG_SIGN = 5;
    localparam int unsigned FLG_INVALID = 6;
    localparam int unsigned FLAG_W = 7;
    localparam int unsigned OP_W = 3;
    localparam int unsigned COUNT_W = 16;
    // operation codes written into the control register
    typedef enum logic [2:0] {
        OP_RECIP_SEED,
        OP_INV_SQRT_SEED,
        OP_SIGN_TRANSFER,
        OP_MIN,
        OP_MAX,
        OP_CLIP
    } fasp_op_t;
endpackage : fasp_pkg

// *** rtl/fasp_operand_class.sv ***
// classifies one operand and flushes denormals to a signed zero
module fasp_operand_class #(
    parameter int unsigned W = 32
) (
    // raw operand
    input wire logic [W-1:0] value_in,
    // flushed operand and its class
    output logic [W-1:0] flushed_out,
    output logic sign_out,
    output logic is_zero_out,
    output logic is_inf_out,
    output logic is_nan_out
);
    logic [fasp_pkg::EXP_W-1:0] exp_field; // biased exponent
    logic frac_nonzero; // any fraction bit set

    assign exp_field = value_in[fasp_pkg::EXP_LSB +: fasp_pkg::EXP_W];
    assign frac_nonzero = |value_in[fasp_pkg::FRAC_W-1:0];
    assign sign_out = value_in[fasp_pkg::SIGN_BIT];

    // denormal and zero both end as a signed zero
    always_comb begin
        if (exp_field == fasp_pkg::EXP_ZERO) begin
            flushed_out = {sign_out, {(W-1){1'b0}}};
        end else begin
            flushed_out = value_in;
        end
    end

    assign is_zero_out = (exp_field == fasp_pkg::EXP_ZERO);
    assign is_inf_out = (exp_field == fasp_pkg::EXP_ALL_ONES) && !frac_nonzero;
    assign is_nan_out = (exp_field == fasp_pkg::EXP_ALL_ONES) && frac_nonzero;
endmodule : fasp_operand_class

// *** rtl/fasp_special_alu.sv ***
// What this block does
// [RL1] reciprocal seed mantissa from 7-bit table
// [RL2] reciprocal exponent -e-1, sign kept, specials
// [RL3] reciprocal zero flag when exponent above 125
// [RL4] reciprocal negative from input, others cleared
// [RL5] seeds overflow on zero; reciprocal invalid NaN
// [RL6] square-root seed is 4-bit estimate
// [RL7] square-root index: exponent LSB, six bits
// [RL8] square-root exponent minus half e, minus one
// [RL9] square-root sign kept, zero infinity, +inf zero
// [RL10] square-root NaN or negative gives ones
// [RL11] square-root zero flag on +infinity only
// [RL12] square-root negative flag on minus zero
// [RL13] square-root invalid on negative or NaN
// [RL14] sign transfer keeps magnitude, takes B sign
// [RL15] sign transfer flushes denormal to zero
// [RL16] minimum returns the smaller operand
// [RL17] minimum of opposite zeros is minus zero
// [RL18] maximum larger; opposite zeros give plus zero
// [RL19] clip passes smaller, else signed magnitude
// [RL20] min, max, clip flush denormals first
// [RL21] NaN input gives all ones result
// [RL22] invalid on NaN, other flags cleared; the reciprocal seed still sets negative from a NaN's sign
// [RL23] zero and negative flags follow result
// [RL24] all seven flags update with result
// [RL25] clip limit uses first operand magnitude
//
// The implementer's own choices: strobed register access and the address map.
module fasp_special_alu #(
    // 0: limiting clip keeps the first operand magnitude
    parameter bit CLIP_USE_LIMIT = 1'b0
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RSTN_IN,
    // register port
    input wire logic [fasp_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [fasp_pkg::DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [fasp_pkg::DATA_W-1:0] REG_RDATA_OUT,
    // write-back to the register file
    output logic [fasp_pkg::DATA_W-1:0] RESULT_OUT,
    output logic [fasp_pkg::FLAG_W-1:0] FLAGS_OUT,
    output logic DONE_OUT
);
    localparam int unsigned TW = fasp_pkg::TABLE_DEPTH;
    localparam int unsigned RSW = fasp_pkg::RECIP_SEED_W;
    localparam int unsigned QSW = fasp_pkg::RSQ_SEED_W;

    // reciprocal table: 2/m truncated at each entry's midpoint
    function automatic logic [TW*RSW-1:0] build_recip();
        logic [TW*RSW-1:0] tab;
        int d;
        int q;
        tab = '0;
        for (int i = 0; i < TW; i++) begin
            // divisor is 1.f with half an index step added, 8 fraction bits
            d = 257 + 2 * i;
            q = 131072 / d;
            tab[i*RSW +: RSW] = RSW'(q - 256);
        end
        return tab;
    endfunction : build_recip

    // square-root table: 2/sqrt(m) or 2/sqrt(2m) by exponent parity
    function automatic logic [TW*QSW-1:0] build_rsq();
        logic [TW*QSW-1:0] tab;
        int mm;
        int num;
        int y;
        tab = '0;
        for (int i = 0; i < TW; i++) begin
            mm = 129 + 2 * (i % 64);
            num = (i >= 64) ? 131072 : 65536;
            y = 16;
            for (int t = 16; t < 32; t++) begin
                if (t * t * mm <= num) begin
                    y = t;
                end
            end
            tab[i*QSW +: QSW] = QSW'(y - 16);
        end
        return tab;
    endfunction : build_rsq

    // tables are elaboration constants, no memory files
    localparam logic [TW*RSW-1:0] RECIP_TABLE = build_recip();
    localparam logic [TW*QSW-1:0] RSQ_TABLE = build_rsq();

    // software visible state
    logic [31:0] opa; // first operand
    logic [31:0] opb; // second operand
    logic [2:0] op_code; // last launched operation
    logic [15:0] op_count; // launched operations
    logic [31:0] result; // last result
    logic [6:0] flags; // last flags word
    // next values
    logic [31:0] next_result;
    logic [6:0] next_flags;
    logic launch; // control write with a legal code
    fasp_pkg::fasp_op_t op_sel; // decoded code

    // operand classes
    logic [31:0] a_flush;
    logic [31:0] b_flush;
    logic a_sign;
    logic b_sign;
    logic a_zero;
    logic a_inf;
    logic a_nan;
    logic b_nan;

    fasp_operand_class #(
        .W(fasp_pkg::DATA_W)
    ) u_class_a (
        .value_in(opa),
        .flushed_out(a_flush),
        .sign_out(a_sign),
        .is_zero_out(a_zero),
        .is_inf_out(a_inf),
        .is_nan_out(a_nan)
    );

    fasp_operand_class #(
        .W(fasp_pkg::DATA_W)
    ) u_class_b (
        .value_in(opb),
        .flushed_out(b_flush),
        .sign_out(b_sign),
        .is_zero_out(),
        .is_inf_out(),
        .is_nan_out(b_nan)
    );

    // launch decode; codes past the last operation are ignored
    assign op_sel = fasp_pkg::fasp_op_t'(REG_WDATA_IN[fasp_pkg::OP_W-1:0]);
    assign launch = REG_WR_IN && (REG_ADDR_IN == fasp_pkg::REG_CTRL)
        && (REG_WDATA_IN[fasp_pkg::OP_W-1:0] <= 3'(fasp_pkg::OP_CLIP));

    // seed helpers
    logic [7:0] a_exp; // biased exponent of operand a
    logic [6:0] recip_idx; // top seven fraction bits
    logic [6:0] rsq_idx; // exponent lsb and six fraction bits
    logic [9:0] a_unbiased; // signed unbiased exponent
    logic [9:0] rsq_exp; // signed biased result exponent
    logic [31:0] a_key; // order keys for comparison
    logic [31:0] b_key;
    logic a_less; // a orders below b
    logic a_mag_less; // |a| below |b|
    logic pick; // result taken from the key compare

    assign a_exp = a_flush[fasp_pkg::EXP_LSB +: fasp_pkg::EXP_W];
    assign recip_idx = a_flush[fasp_pkg::FRAC_W-1 -: fasp_pkg::RECIP_IDX_W]; // RL1
    assign rsq_idx = {a_exp[0], a_flush[fasp_pkg::FRAC_W-1 -: fasp_pkg::RSQ_FRAC_IDX_W]}; // RL7
    assign a_unbiased = {2'b00, a_exp} - fasp_pkg::EXP_BIAS;
    // floor of e/2 through arithmetic shift, then negate and less one
    assign rsq_exp = fasp_pkg::RSQ_EXP_BASE - 10'($signed(a_unbiased) >>> 1); // RL8

    // keys make the signed order an unsigned one; minus zero sorts below plus zero
    assign a_key = a_sign ? ~a_flush : {1'b1, a_flush[30:0]};
    assign b_key = b_sign ? ~b_flush : {1'b1, b_flush[30:0]};
    assign a_less = a_key < b_key;
    assign a_mag_less = a_flush[30:0] < b_flush[30:0];
    assign pick = a_less;

    // result and flags of the selected operation
    always_comb begin
        next_result = fasp_pkg::RESET_WORD;
        next_flags = '0;
        case (op_sel)
            fasp_pkg::OP_RECIP_SEED: begin
                if (a_nan) begin
                    next_result = fasp_pkg::NAN_RESULT; // RL2
                end else if (a_zero) begin
                    // zero in, signed infinity out
                    next_result = {a_sign, fasp_pkg::EXP_ALL_ONES, 23'h00_0000}; // RL2
                end else if (a_exp > fasp_pkg::RECIP_ZERO_LIMIT) begin
                    // too large: seed underflows to signed zero
                    next_result = {a_sign, 31'h0000_0000}; // RL3
                end else begin
                    next_result = {a_sign, fasp_pkg::RECIP_EXP_BASE - a_exp,
                        RECIP_TABLE[{recip_idx, 3'b000} +: RSW], 15'h0000}; // RL1 RL2
                end
                next_flags[fasp_pkg::FLG_ZERO] = !a_nan && !a_zero
                    && (a_exp > fasp_pkg::RECIP_ZERO_LIMIT); // RL3
                next_flags[fasp_pkg::FLG_NEGATIVE] = a_sign; // RL4
                next_flags[fasp_pkg::FLG_OVERFLOW] = a_zero; // RL5
                next_flags[fasp_pkg::FLG_INVALID] = a_nan; // RL5
            end
            fasp_pkg::OP_INV_SQRT_SEED: begin
                if (a_nan || (a_sign && !a_zero)) begin
                    next_result = fasp_pkg::NAN_RESULT; // RL10
                end else if (a_zero) begin
                    next_result = {a_sign, fasp_pkg::EXP_ALL_ONES, 23'h00_0000}; // RL9
                end else if (a_inf) begin
                    next_result = fasp_pkg::RESET_WORD; // RL9
                end else begin
                    // four seed bits then zero fill
                    next_result = {a_sign, rsq_exp[7:0],
                        RSQ_TABLE[{rsq_idx, 2'b00} +: QSW], 19'h0_0000}; // RL6 RL7 RL8
                end
                next_flags[fasp_pkg::FLG_ZERO] = a_inf && !a_sign; // RL11
                next_flags[fasp_pkg::FLG_NEGATIVE] = a_zero && a_sign; // RL12
                next_flags[fasp_pkg::FLG_OVERFLOW] = a_zero; // RL5 RL9
                next_flags[fasp_pkg::FLG_INVALID] = a_nan || (a_sign && !a_zero); // RL13
            end
            fasp_pkg::OP_SIGN_TRANSFER: begin
                // flushed magnitude keeps a denormal from leaking
                next_result = {b_sign, a_flush[30:0]}; // RL14 RL15
            end
            fasp_pkg::OP_MIN: begin
                next_result = pick ? a_flush : b_flush; // RL16 RL17 RL20
            end
            fasp_pkg::OP_MAX: begin
                next_result = pick ? b_flush : a_flush; // RL18 RL20
            end
            fasp_pkg::OP_CLIP: begin
                if (a_mag_less || !CLIP_USE_LIMIT) begin
                    // smaller first operand passes; with CLIP_USE_LIMIT clear, so does the limiting case
                    next_result = a_flush; // RL19 RL25
                end else begin
                    next_result = {a_sign, b_flush[30:0]}; // RL19
                end
            end
            default: begin
                next_result = fasp_pkg::RESET_WORD;
            end
        endcase
        // two-operand group shares NaN handling and result flags
        if (op_sel inside {fasp_pkg::OP_SIGN_TRANSFER, fasp_pkg::OP_MIN,
                fasp_pkg::OP_MAX, fasp_pkg::OP_CLIP}) begin
            if (a_nan || b_nan) begin
                next_result = fasp_pkg::NAN_RESULT; // RL21
                next_flags[fasp_pkg::FLG_INVALID] = 1'b1; // RL22
            end else begin
                next_flags[fasp_pkg::FLG_ZERO] = (next_result[30:0] == 31'h0000_0000); // RL23
                next_flags[fasp_pkg::FLG_NEGATIVE] = next_result[fasp_pkg::SIGN_BIT]; // RL23
            end
        end
        // underflow, carry and sign flags never set here
        next_flags[fasp_pkg::FLG_UNDERFLOW] = 1'b0; // RL4 RL11 RL22
        next_flags[fasp_pkg::FLG_CARRY] = 1'b0;
        next_flags[fasp_pkg::FLG_SIGN] = 1'b0;
    end

    // operand registers
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            opa <= fasp_pkg::RESET_WORD;
            opb <= fasp_pkg::RESET_WORD;
        end else if (REG_WR_IN) begin
            // a write to any other offset is dropped
            if (REG_ADDR_IN == fasp_pkg::REG_OPA) begin
                opa <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == fasp_pkg::REG_OPB) begin
                opb <= REG_WDATA_IN;
            end
        end
    end

    // result and flags move together on a launch
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            result <= fasp_pkg::RESET_WORD;
            flags <= '0;
            op_code <= '0;
            op_count <= '0;
        end else if (launch) begin
            result <= next_result; // RL24
            flags <= next_flags; // RL24
            op_code <= REG_WDATA_IN[fasp_pkg::OP_W-1:0];
            op_count <= op_count + 16'h0001;
        end
    end

    // write-back copies for the register file
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            RESULT_OUT <= fasp_pkg::RESET_WORD;
            FLAGS_OUT <= '0;
            DONE_OUT <= 1'b0;
        end else begin
            DONE_OUT <= launch;
            if (launch) begin
                RESULT_OUT <= next_result; // RL24
                FLAGS_OUT <= next_flags; // RL24
            end
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            REG_RDATA_OUT <= fasp_pkg::RESET_WORD;
        end else if (!REG_RD_IN) begin
            REG_RDATA_OUT <= fasp_pkg::RESET_WORD;
        end else if (REG_ADDR_IN == fasp_pkg::REG_OPA) begin
            REG_RDATA_OUT <= opa;
        end else if (REG_ADDR_IN == fasp_pkg::REG_OPB) begin
            REG_RDATA_OUT <= opb;
        end else if (REG_ADDR_IN == fasp_pkg::REG_CTRL) begin
            REG_RDATA_OUT <= {29'h0000_0000, op_code};
        end else if (REG_ADDR_IN == fasp_pkg::REG_RESULT) begin
            REG_RDATA_OUT <= result;
        end else if (REG_ADDR_IN == fasp_pkg::REG_FLAGS) begin
            REG_RDATA_OUT <= {25'h000_0000, flags};
        end else if (REG_ADDR_IN == fasp_pkg::REG_COUNT) begin
            REG_RDATA_OUT <= {16'h0000, op_count};
        end else begin
            // unmapped offsets read as zero
            REG_RDATA_OUT <= fasp_pkg::RESET_WORD;
        end
    end
endmodule : fasp_special_alu

// *** tb/fasp_partner.sv ***
// sequencer side: drives the register port like the core would
module fasp_partner (
    // clock
    input wire logic clk_in,
    // request towards the block
    output logic [fasp_pkg::ADDR_W-1:0] addr_out,
    output logic [fasp_pkg::DATA_W-1:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    // answer from the block
    input wire logic [fasp_pkg::DATA_W-1:0] rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet bus at time zero
    initial begin
        addr_out = 8'h00;
        wdata_out = 32'h0000_0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // one write; released lines flip so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask : wr
    // one read; data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1 d = rdata_in;
    endtask : rd
endmodule : fasp_partner

// *** tb/fasp_special_alu_monitor.sv ***
// port-level checker for the special-function alu
module fasp_special_alu_monitor (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RSTN_IN,
    // register port
    input wire logic [fasp_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [fasp_pkg::DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [fasp_pkg::DATA_W-1:0] REG_RDATA_OUT,
    // write-back side
    input wire logic [fasp_pkg::DATA_W-1:0] RESULT_OUT,
    input wire logic [fasp_pkg::FLAG_W-1:0] FLAGS_OUT,
    input wire logic DONE_OUT
);
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    // legal control write, the only cause of a launch
    logic launch;
    assign launch = REG_WR_IN && REG_ADDR_IN == fasp_pkg::REG_CTRL && REG_WDATA_IN[2:0] <= 3'h5;
    sequence launch_s;
        launch;
    endsequence
    sequence rd_result_s;
        REG_RD_IN && REG_ADDR_IN == fasp_pkg::REG_RESULT;
    endsequence
    launch_done_a: assert property (launch_s |=> DONE_OUT) else $error("no done after launch");
    done_cause_a: assert property (DONE_OUT |-> $past(launch)) else $error("done without launch");
    result_hold_a: assert property (!DONE_OUT |-> $stable(RESULT_OUT) && $stable(FLAGS_OUT))
        else $error("result moved without launch");
    ones_invalid_a: assert property (DONE_OUT |->
        FLAGS_OUT[fasp_pkg::FLG_INVALID] == (RESULT_OUT == 32'hFFFF_FFFF))
        else $error("invalid flag and all-ones result disagree");
    cleared_flags_a: assert property (DONE_OUT |-> (FLAGS_OUT & 7'h32) == 7'h00)
        else $error("always-clear flag set");
    zero_flag_a: assert property (DONE_OUT |->
        FLAGS_OUT[fasp_pkg::FLG_ZERO] == (RESULT_OUT[30:0] == 31'h0000_0000))
        else $error("zero flag wrong");
    overflow_inf_a: assert property (DONE_OUT && FLAGS_OUT[fasp_pkg::FLG_OVERFLOW] |->
        RESULT_OUT[30:0] == 31'h7F80_0000)
        else $error("overflow without infinity");
    neg_sign_a: assert property (DONE_OUT && FLAGS_OUT[fasp_pkg::FLG_NEGATIVE] |-> RESULT_OUT[31])
        else $error("negative flag on positive result");
    rd_result_a: assert property (rd_result_s |=> REG_RDATA_OUT == $past(RESULT_OUT))
        else $error("result read wrong");
endmodule : fasp_special_alu_monitor
bind fasp_special_alu fasp_special_alu_monitor i_fasp_special_alu_monitor (.REF_CLK_IN(REF_CLK_IN),
    .RSTN_IN(RSTN_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .RESULT_OUT(RESULT_OUT), .FLAGS_OUT(FLAGS_OUT),
    .DONE_OUT(DONE_OUT));

// *** tb/fasp_special_alu_tb.sv ***
module fasp_special_alu_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and port wires
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, result;
    logic [6:0] flags;
    logic wr, rd, done;
    int mismatches = 0;
    int n_tests = 0;
    int n_ops = 0;
    int seed = 64;
    // zeros, infinities, nan, denormals, exponent edges
    logic [31:0] pool [12] = '{32'h0000_0000, 32'h8000_0000, 32'h7F80_0000, 32'hFF80_0000, 32'h7FC0_0000,
        32'h0000_0001, 32'h8040_0000, 32'h3F80_0000, 32'hBFC0_0000, 32'h7E80_0000, 32'h7E00_0000, 32'h0080_0000};
    always #25 ref_clk = ~ref_clk;
    fasp_partner i_fasp_partner (.clk_in(ref_clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
        .rdata_in(rdata));
    fasp_special_alu i_fasp_special_alu (.REF_CLK_IN(ref_clk), .RSTN_IN(rstn), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .RESULT_OUT(result),
        .FLAGS_OUT(flags), .DONE_OUT(done));
    // reference: {flags, result}, seed mantissas left at zero
    function automatic logic [38:0] model(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b);
        logic [31:0] fa, fb, r;
        logic [6:0] f;
        logic nan;
        int ka, kb, e;
        fa = a[30:23] == 8'h00 ? {a[31], 31'h0000_0000} : a;
        fb = b[30:23] == 8'h00 ? {b[31], 31'h0000_0000} : b;
        nan = a[30:23] == 8'hFF && a[22:0] != 23'h0;
        ka = fa[31] ? -int'(fa[30:0]) : int'(fa[30:0]);
        kb = fb[31] ? -int'(fb[30:0]) : int'(fb[30:0]);
        e = int'(fa[30:23]) - 127;
        f = 7'h00;
        f[3] = op < 3'h2 && fa[30:0] == 31'h0000_0000;
        case (op)
            3'h0: r = fa[30:23] > 8'hFC ? {a[31], 31'h0000_0000} : {a[31], 8'(253 - int'(fa[30:23])), 23'h0};
            3'h1: r = fa == 32'h7F80_0000 ? 32'h0000_0000 : {1'b0, 8'(126 - (e >>> 1)), 23'h0};
            3'h2: r = {b[31], fa[30:0]};
            3'h3: r = ka < kb ? fa : (kb < ka ? fb : fa | fb);
            3'h4: r = ka > kb ? fa : (kb > ka ? fb : fa & fb);
            default: r = fa;
        endcase
        if (f[3]) r = {a[31], 31'h7F80_0000};
        if (op > 3'h1) nan = nan || (b[30:23] == 8'hFF && b[22:0] != 23'h0);
        if (op == 3'h1 && a[31] && fa[30:0] != 31'h0000_0000) nan = 1'b1;
        if (nan) r = 32'hFFFF_FFFF;
        f[6] = nan;
        f[0] = r[30:0] == 31'h0000_0000;
        f[2] = op == 3'h0 ? a[31] : (op == 3'h1 ? fa == 32'h8000_0000 : r[31] && !nan);
        return {f, r};
    endfunction : model
    // compare and count
    task automatic check(input logic [38:0] seen, input logic [38:0] want);
        n_tests++;
        if (seen !== want) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h wanted %h", $time, seen, want);
        end
    endtask : check
    // one launch through the register port, then flags read back
    task automatic run(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b);
        logic [38:0] e;
        logic [31:0] m, d;
        real x, y;
        e = model(op, a, b);
        m = 32'hFFFF_FFFF;
        // table bits of a normal seed are judged by accuracy, not value
        if (op < 3'h2 && e[30:23] != 8'h00 && e[30:23] != 8'hFF) m = op[0] ? 32'hFF87_FFFF : 32'hFF80_7FFF;
        i_fasp_partner.wr(fasp_pkg::REG_OPA, a);
        i_fasp_partner.wr(fasp_pkg::REG_OPB, b);
        i_fasp_partner.wr(fasp_pkg::REG_CTRL, {29'h0, op});
        n_ops++;
        #1 check({38'h0, done}, 39'h1);
        check({flags, result & m}, e);
        x = 1.0 + a[22:0] / 8388608.0;
        if (op == 3'h1 && !a[23]) x = 2.0 * x;
        y = (op == 3'h1 ? 2.0 / $sqrt(x) : 2.0 / x) - 1.0 - result[22:0] / 8388608.0;
        if (m != 32'hFFFF_FFFF) check({38'h0, (y < 0.0 ? -y : y) <= (op[0] ? 0.125 : 0.015625)}, 39'h1);
        i_fasp_partner.rd(fasp_pkg::REG_FLAGS, d);
        check({7'h00, d}, {32'h0000_0000, e[38:32]});
    endtask : run
    // verdict, the single end of the run
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    // hang guard, well beyond the expected 8.7k cycles
    initial begin
        #(40000 * 50);
        mismatches++;
        stop_test();
    end
    // main sequence
    initial begin
        logic [31:0] a, b, d;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        // all places read zero out of reset, unmapped one too
        for (int i = 0; i < 7; i++) begin
            i_fasp_partner.rd(8'(4 * i), d);
            check({7'h00, d}, 39'h0);
        end
        // every special pair, then random words, through all six codes
        for (int i = 0; i < 180; i++) begin
            a = i < 144 ? pool[i % 12] : $random(seed);
            b = i < 144 ? pool[i / 12] : $random(seed);
            for (int op = 0; op < 6; op++) run(3'(op), a, b);
        end
        run(3'h4, 32'h4000_0000, 32'hC000_0000);
        // refused: unknown codes and read-only places
        for (int i = 6; i < 8; i++) begin
            i_fasp_partner.wr(fasp_pkg::REG_CTRL, 32'(i));
            #1 check({38'h0, done}, 39'h0);
        end
        i_fasp_partner.wr(fasp_pkg::REG_RESULT, 32'h1234_5678);
        i_fasp_partner.wr(fasp_pkg::REG_COUNT, 32'h1234_5678);
        i_fasp_partner.rd(fasp_pkg::REG_RESULT, d);
        check({7'h00, d}, {7'h00, 32'h4000_0000});
        i_fasp_partner.rd(fasp_pkg::REG_OPB, d);
        check({7'h00, d}, {7'h00, 32'hC000_0000});
        // refused codes leave the last legal code in place
        i_fasp_partner.rd(fasp_pkg::REG_CTRL, d);
        check({7'h00, d}, 39'h4);
        i_fasp_partner.rd(fasp_pkg::REG_COUNT, d);
        check({7'h00, d}, 39'(n_ops));
        stop_test();
    end
endmodule : fasp_special_alu_tb
